/* File: verilog/ckdrc_cfg.svh */
// Offsets, field positions, reset values for the clock divider reset control.
// Assumes 8-bit registers reached over the device's own control port.
`ifndef CKDRC_CFG_SVH
`define CKDRC_CFG_SVH

`define CKDRC_OFS_SERIAL_DIR     8'h09
`define CKDRC_OFS_DSP_INPUT      8'h0A
`define CKDRC_OFS_DIV_RESETS     8'h0C
`define CKDRC_OFS_CLK_SOURCE     8'h0D

`define CKDRC_BIT_DSP_INPUT      7
`define CKDRC_BIT_DSP_REL        6
`define CKDRC_BIT_DAC_REL        5
`define CKDRC_BIT_NCP_REL        4
`define CKDRC_BIT_OSR_REL        3
`define CKDRC_BIT_SYN_REL        2
`define CKDRC_BIT_BCK_REL        1
`define CKDRC_BIT_FRM_REL        0
`define CKDRC_BIT_STATUS         6
`define CKDRC_BIT_BCK_OE         4
`define CKDRC_PLL_REF_HI         5
`define CKDRC_PLL_REF_LO         4
`define CKDRC_DSP_SRC_HI         2
`define CKDRC_DSP_SRC_LO         0

`define CKDRC_RST_DSP_INPUT      1'h0
`define CKDRC_RST_DIV_RESETS     7'h7D
`define CKDRC_RST_PLL_REF        2'h0
`define CKDRC_RST_DSP_SRC        3'h0
`define CKDRC_RST_BCK_OE         1'h0
`define CKDRC_DSP_SRC_LAST       3'h5

`endif

/* File: verilog/ckdrc_pkg.sv */
// Types shared by the clock divider reset control.
// Assumes ckdrc_cfg.svh holds the register offsets, field positions and reset values.
package ckdrc_pkg;

  typedef enum logic [2:0] {
    CKDRC_DSP_AUTO,
    CKDRC_DSP_PLL,
    CKDRC_DSP_OSC,
    CKDRC_DSP_MCLK,
    CKDRC_DSP_BCLK,
    CKDRC_DSP_GPIO
  } ckdrc_dsp_src_type;

  typedef enum logic [1:0] {
    CKDRC_REF_MCLK,
    CKDRC_REF_BCLK,
    CKDRC_REF_OSC,
    CKDRC_REF_GPIO
  } ckdrc_pll_ref_type;

endpackage : ckdrc_pkg

/* File: verilog/ckdrc_top.sv */
// Clock divider reset and clock source control registers.
// Assumes a host register port on clk; frame_start and auto_setup_ref come
// from logic on clk, auto_setup_active and status_flag_pin from outside.
`timescale 1ns/1ps
`include "ckdrc_cfg.svh"

// Notes on behaviour
// - Host-written top bit of DSP input register drives the DSP input port.
// - DSP divider release low holds DSP divider reset; resets to one.
// - DAC divider release low stops DAC clock and derivatives; resets one.
// - Charge-pump release low stops oversampling clock divider; resets one.
// - Either sync release cleared stops DAC clocks immediately.
// - Both sync releases set restart dividers at next frame start.
// - Master bit-clock divider held while its release is low; resets zero.
// - Master frame-clock divider held while its release is low; resets one.
// - PLL reference choice is overridden while auto clock setup runs.
// - DSP source picks one of six clocks; reserved codes mute it.
// - Bit-clock output enable makes the device drive the bit clock.
module ckdrc_top #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [ADDR_W-1:0]          reg_addr,
  input  wire logic [DATA_W-1:0]          reg_wdata,
  input  wire logic                       reg_we,
  input  wire logic                       reg_re,
  output logic      [DATA_W-1:0]          reg_rdata,
  input  wire logic                       frame_start,
  input  wire logic                       auto_setup_active,
  input  wire ckdrc_pkg::ckdrc_pll_ref_type auto_setup_ref,
  input  wire logic                       status_flag_pin,
  input  wire logic                       master_bitclk_gen,
  input  wire logic                       bitclk_in,
  output logic                            bitclk_out,
  output logic                            bitclk_oe_n,
  output logic                            bitclk_seen,
  output logic                            dsp_host_input_bit,
  output logic                            dsp_div_run,
  output logic                            dac_div_run,
  output logic                            osr_div_run,
  output logic                            master_bitclk_div_run,
  output logic                            master_frameclk_div_run,
  output ckdrc_pkg::ckdrc_pll_ref_type    pll_ref_eff,
  output ckdrc_pkg::ckdrc_dsp_src_type    dsp_src_eff,
  output logic                            dsp_clk_mute
);
  import ckdrc_pkg::*;

  // Refused at elaboration: the bit map assumes byte registers
  if (DATA_W != 8 || ADDR_W < 8) begin : g_bad_width
    $error("ckdrc_top: needs DATA_W of 8 and ADDR_W of at least 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic        dsp_in_reg;
  logic [6:0]  div_rel_reg;
  logic [1:0]  pll_ref_reg;
  logic [2:0]  dsp_src_reg;
  logic        bck_oe_reg;
  logic        sync_run_reg;
  logic [1:0]  auto_sync_reg;
  logic [1:0]  stat_sync_reg;
  logic [1:0]  bclk_sync_reg;

  wire hit_dir = reg_addr == ADDR_W'(`CKDRC_OFS_SERIAL_DIR);
  wire hit_dsp = reg_addr == ADDR_W'(`CKDRC_OFS_DSP_INPUT);
  wire hit_div = reg_addr == ADDR_W'(`CKDRC_OFS_DIV_RESETS);
  wire hit_src = reg_addr == ADDR_W'(`CKDRC_OFS_CLK_SOURCE);

  // Reserved bits are not stored, so writes to them do nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_in_reg  <= `CKDRC_RST_DSP_INPUT;
      div_rel_reg <= `CKDRC_RST_DIV_RESETS;
      pll_ref_reg <= `CKDRC_RST_PLL_REF;
      dsp_src_reg <= `CKDRC_RST_DSP_SRC;
      bck_oe_reg  <= `CKDRC_RST_BCK_OE;
    end else if (reg_we) begin
      if (hit_dsp)
        dsp_in_reg <= reg_wdata[`CKDRC_BIT_DSP_INPUT];
      if (hit_div)
        div_rel_reg <= reg_wdata[6:0];
      if (hit_src) begin
        pll_ref_reg <= reg_wdata[`CKDRC_PLL_REF_HI:`CKDRC_PLL_REF_LO];
        dsp_src_reg <= reg_wdata[`CKDRC_DSP_SRC_HI:`CKDRC_DSP_SRC_LO];
      end
      if (hit_dir)
        bck_oe_reg <= reg_wdata[`CKDRC_BIT_BCK_OE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage 1 is read by logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_sync_reg <= 2'h0;
      stat_sync_reg <= 2'h0;
      bclk_sync_reg <= 2'h0;
    end else begin
      auto_sync_reg <= {auto_sync_reg[0], auto_setup_active};
      stat_sync_reg <= {stat_sync_reg[0], status_flag_pin};
      bclk_sync_reg <= {bclk_sync_reg[0], bitclk_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback: one cycle after reg_re; unmapped addresses read zero
  wire [7:0] rd_dir = {3'h0, bck_oe_reg, 4'h0};
  wire [7:0] rd_dsp = {dsp_in_reg, 7'h00};
  wire [7:0] rd_div = {1'h0, div_rel_reg};
  wire [7:0] rd_src = {1'h0, stat_sync_reg[1], pll_ref_reg,
                       1'h0, dsp_src_reg};
  wire [7:0] rd_mux = hit_dir ? rd_dir :
                      hit_dsp ? rd_dsp :
                      hit_div ? rd_div :
                      hit_src ? rd_src : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_re)
      reg_rdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock synchroniser: stop at once, restart on a frame boundary
  wire sync_rel = div_rel_reg[`CKDRC_BIT_OSR_REL] &
                  div_rel_reg[`CKDRC_BIT_SYN_REL];
  wire sync_run_next = !sync_rel ? 1'b0 :
                       frame_start ? 1'b1 : sync_run_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sync_run_reg <= 1'b1;
    else
      sync_run_reg <= sync_run_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective source selects
  wire [1:0] pll_ref_next = auto_sync_reg[1] ? auto_setup_ref
                                             : pll_ref_reg;
  wire       dsp_mute_next = dsp_src_reg > `CKDRC_DSP_SRC_LAST;
  wire [2:0] dsp_src_next = dsp_mute_next ? 3'h0 : dsp_src_reg;
  wire       master_run = div_rel_reg[`CKDRC_BIT_BCK_REL];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_host_input_bit      <= 1'b0;
      dsp_div_run             <= 1'b1;
      dac_div_run             <= 1'b1;
      osr_div_run             <= 1'b1;
      master_bitclk_div_run   <= 1'b0;
      master_frameclk_div_run <= 1'b1;
      pll_ref_eff             <= CKDRC_REF_MCLK;
      dsp_src_eff             <= CKDRC_DSP_AUTO;
      dsp_clk_mute            <= 1'b0;
      bitclk_out              <= 1'b0;
      bitclk_oe_n             <= 1'b1;
      bitclk_seen             <= 1'b0;
    end else begin
      dsp_host_input_bit      <= dsp_in_reg;
      dsp_div_run             <= div_rel_reg[`CKDRC_BIT_DSP_REL];
      dac_div_run             <= div_rel_reg[`CKDRC_BIT_DAC_REL]
                                 & sync_run_next;
      osr_div_run             <= div_rel_reg[`CKDRC_BIT_NCP_REL];
      master_bitclk_div_run   <= master_run;
      master_frameclk_div_run <= div_rel_reg[`CKDRC_BIT_FRM_REL];
      pll_ref_eff             <= ckdrc_pll_ref_type'(pll_ref_next);
      dsp_src_eff             <= ckdrc_dsp_src_type'(dsp_src_next);
      dsp_clk_mute            <= dsp_mute_next;
      // Held divider drives a steady low rather than a runt edge
      bitclk_out              <= master_bitclk_gen & master_run;
      bitclk_oe_n             <= !bck_oe_reg;
      bitclk_seen             <= bclk_sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_dsp_input_follow: assert property (
    reg_we && hit_dsp |-> ##2 dsp_host_input_bit == $past(reg_wdata[7], 2))
    else $error("DSP input bit did not follow write");
  a_dsp_div_hold: assert property (
    reg_we && hit_div && !reg_wdata[6] |-> ##2 !dsp_div_run)
    else $error("DSP divider not held");
  a_dac_div_hold: assert property (
    reg_we && hit_div && !reg_wdata[5] |-> ##2 !dac_div_run)
    else $error("DAC divider not held");
  a_osr_div_hold: assert property (
    reg_we && hit_div && reg_wdata[4] != osr_div_run |-> ##2
    osr_div_run == $past(reg_wdata[4], 2))
    else $error("Oversampling divider wrong");
  a_sync_stop_now: assert property (
    reg_we && hit_div && !(reg_wdata[3] && reg_wdata[2])
    ##1 !(reg_we && hit_div) |-> ##1 !dac_div_run [*2])
    else $error("DAC clocks not stopped at once");
  a_sync_frame_wait: assert property (
    !sync_run_reg && !frame_start |=> !sync_run_reg)
    else $error("Restart before frame start");
  a_sync_frame_go: assert property (
    !sync_run_reg && sync_rel && frame_start |=> sync_run_reg)
    else $error("No restart on frame start");
  a_master_bck_hold: assert property (
    !master_bitclk_div_run |-> !bitclk_out)
    else $error("Bit clock runs while held");
  a_master_frm_hold: assert property (
    reg_we && hit_div && !reg_wdata[0] |-> ##2 !master_frameclk_div_run)
    else $error("Frame divider not held");
  a_src_readback: assert property (
    reg_re && hit_src |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("Reserved source bits not zero");
  a_auto_override: assert property (
    auto_sync_reg[1] |=> pll_ref_eff == $past(auto_setup_ref))
    else $error("Auto setup did not override reference");
  a_dsp_src_mute: assert property (
    dsp_src_reg > 3'h5 |=> dsp_clk_mute && dsp_src_eff == CKDRC_DSP_AUTO)
    else $error("Reserved DSP source not muted");
  a_bck_drive: assert property (
    reg_we && hit_dir |-> ##2 bitclk_oe_n == !$past(reg_wdata[4], 2))
    else $error("Bit clock enable wrong");

  c_sync_restart: cover property (!sync_run_reg ##[1:20] sync_run_reg);
  c_dsp_written:  cover property (reg_we && hit_dsp && reg_wdata[7]);
  c_master_mode:  cover property (!bitclk_oe_n && master_bitclk_div_run);
  c_auto_active:  cover property (auto_sync_reg[1]);

endmodule : ckdrc_top

/* File: testbench/ckdrc_host.sv */
// Host model: writes and reads registers over the register port.
// Assumes a rising-edge design; requests change on the falling edge.
`timescale 1ns/1ps
module ckdrc_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_we,
  output logic            reg_re
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
  end

  // Data inverted after the strobe so a stale value cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_we    = 1'b1;
    @(negedge clk);
    reg_we    = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_re   = 1'b1;
    @(negedge clk);
    reg_re   = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : ckdrc_host

/* File: testbench/ckdrc_top_tb_top.sv */
// Self-checking bench for the clock divider reset control.
// Assumes ckdrc_host drives the register port.
`timescale 1ns/1ps
module ckdrc_top_tb_top;
  import ckdrc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, frm = 1'b0, auto_on = 1'b0;
  logic stat = 1'b0, mgen = 1'b0, bck_in = 1'b0, we, re;
  logic [7:0] addr, wdata, rdata;
  ckdrc_pll_ref_type auto_ref = CKDRC_REF_MCLK, pll_ref;
  ckdrc_dsp_src_type dsp_src;
  logic bck_out, bck_oe_n, bck_seen, dsp_in, r_dsp, r_dac, r_osr, r_mb, r_mf;
  logic mute;
  int err_count = 0, n_checks = 0;
  wire [7:0] runs = {3'h0, r_dsp, r_dac, r_osr, r_mb, r_mf};

  always #5 clk = ~clk;

  ckdrc_host ckdrc_host_i (.clk(clk), .reg_rdata(rdata), .reg_addr(addr),
    .reg_wdata(wdata), .reg_we(we), .reg_re(re));
  ckdrc_top ckdrc_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(rdata),
    .frame_start(frm), .auto_setup_active(auto_on), .auto_setup_ref(auto_ref),
    .status_flag_pin(stat), .master_bitclk_gen(mgen), .bitclk_in(bck_in),
    .bitclk_out(bck_out), .bitclk_oe_n(bck_oe_n), .bitclk_seen(bck_seen),
    .dsp_host_input_bit(dsp_in), .dsp_div_run(r_dsp), .dac_div_run(r_dac),
    .osr_div_run(r_osr), .master_bitclk_div_run(r_mb),
    .master_frameclk_div_run(r_mf), .pll_ref_eff(pll_ref),
    .dsp_src_eff(dsp_src), .dsp_clk_mute(mute));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    ckdrc_host_i.rd(a, d);
    chk(d, exp);
  endtask : rdchk
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic pulse_frame;
    @(negedge clk);
    frm = 1'b1;
    @(negedge clk);
    frm = 1'b0;
    @(negedge clk);
  endtask : pulse_frame

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(8'h0C, 8'h7D);
    rdchk(8'h0A, 8'h00);
    rdchk(8'h0D, 8'h00);
    chk(runs, 8'h1D);
    chk({7'h00, bck_oe_n}, 8'h01);
    $display("test reset done");
  endtask : t_reset
  task automatic t_dsp_input;
    ckdrc_host_i.wr(8'h0A, 8'hFF);
    settle(1);
    chk({7'h00, dsp_in}, 8'h01);
    rdchk(8'h0A, 8'h80);
    ckdrc_host_i.wr(8'h0B, 8'h00);
    rdchk(8'h0B, 8'h00);
    chk({7'h00, dsp_in}, 8'h01);
    ckdrc_host_i.wr(8'h0A, 8'h7F);
    settle(1);
    chk({7'h00, dsp_in}, 8'h00);
    $display("test dsp input done");
  endtask : t_dsp_input
  task automatic t_dividers;
    ckdrc_host_i.wr(8'h0C, 8'h00);
    settle(1);
    chk(runs, 8'h00);
    ckdrc_host_i.wr(8'h0C, 8'hFF);
    settle(1);
    chk(runs, 8'h17);
    rdchk(8'h0C, 8'h7F);
    $display("test dividers done");
  endtask : t_dividers
  task automatic t_sync;
    logic [7:0] clr [2] = '{8'h79, 8'h75};
    pulse_frame();
    chk({7'h00, r_dac}, 8'h01);
    foreach (clr[i]) begin
      ckdrc_host_i.wr(8'h0C, clr[i]);
      settle(1);
      chk({7'h00, r_dac}, 8'h00);
      pulse_frame();
      chk({7'h00, r_dac}, 8'h00);
      ckdrc_host_i.wr(8'h0C, 8'h7D);
      settle(3);
      chk({7'h00, r_dac}, 8'h00);
      pulse_frame();
      chk({7'h00, r_dac}, 8'h01);
    end
    $display("test sync done");
  endtask : t_sync
  task automatic t_source;
    for (int c = 0; c < 8; c++) begin
      ckdrc_host_i.wr(8'h0D, 8'(c));
      settle(1);
      chk({5'h00, dsp_src}, (c < 6) ? 8'(c) : 8'h00);
      chk({7'h00, mute}, (c < 6) ? 8'h00 : 8'h01);
    end
    for (int r = 0; r < 4; r++) begin
      ckdrc_host_i.wr(8'h0D, 8'(r << 4));
      settle(1);
      chk({6'h00, pll_ref}, 8'(r));
    end
    auto_ref = CKDRC_REF_OSC;
    auto_on = 1'b1;
    stat = 1'b1;
    ckdrc_host_i.wr(8'h0D, 8'hFF);
    settle(5);
    chk({6'h00, pll_ref}, 8'h02);
    rdchk(8'h0D, 8'h77);
    auto_on = 1'b0;
    stat = 1'b0;
    settle(5);
    chk({6'h00, pll_ref}, 8'h03);
    rdchk(8'h0D, 8'h37);
    $display("test source done");
  endtask : t_source
  task automatic t_master;
    ckdrc_host_i.wr(8'h09, 8'h10);
    mgen = 1'b1;
    bck_in = 1'b1;
    ckdrc_host_i.wr(8'h0C, 8'h7F);
    settle(3);
    chk({5'h00, bck_seen, bck_oe_n, bck_out}, 8'h05);
    ckdrc_host_i.wr(8'h0C, 8'h7D);
    ckdrc_host_i.wr(8'h09, 8'h00);
    settle(1);
    chk({6'h00, bck_oe_n, bck_out}, 8'h02);
    $display("test master done");
  endtask : t_master
  task automatic t_rerun;
    ckdrc_host_i.wr(8'h0A, 8'h80);
    ckdrc_host_i.wr(8'h0C, 8'h00);
    @(negedge clk);
    rst_n = 1'b0;
    settle(3);
    rst_n = 1'b1;
    rdchk(8'h0C, 8'h7D);
    chk(runs, 8'h1D);
    chk({7'h00, dsp_in}, 8'h00);
    $display("test rerun done");
  endtask : t_rerun

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_dsp_input();
    t_dividers();
    t_sync();
    t_source();
    t_master();
    t_rerun();
    results();
  end
  // Tests need about 160 cycles; over a hundred times that means a hang
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule : ckdrc_top_tb_top
